//--- verilog/sfr_reset_initializer.sv
// Special function register file with reset and wake-up initialisation
module sfr_reset_initializer (
	input  wire logic                          clk_i,
	input  wire logic                          reset_n_i,
	input  wire logic                          clk_en_i,
	// Avalon-MM slave
	input  wire logic [sfr_init_pkg::ADDR_W-1:0] address_i,
	input  wire logic                          read_i,
	input  wire logic                          write_i,
	input  wire logic [31:0]                   writedata_i,
	input  wire logic [3:0]                    byteenable_i,
	output logic      [31:0]                   readdata_o,
	output logic                               waitrequest_o,
	// Reset and wake events from the reset source logic
	input  wire logic                          power_on_i,
	input  wire logic                          brown_out_i,
	input  wire logic                          master_clear_i,
	input  wire logic                          watchdog_reset_i,
	input  wire logic                          instr_reset_i,
	input  wire logic                          stack_reset_i,
	input  wire logic                          wake_watchdog_i,
	input  wire logic                          wake_irq_i,
	input  wire logic [2:0]                    reset_cause_q_i,
	// Processor core
	input  wire logic [sfr_init_pkg::PC_W-1:0] pc_i,
	input  wire logic                          wake_irq_high_i,
	input  wire logic                          global_high_irq_enable_i,
	input  wire logic                          global_low_irq_enable_i,
	input  wire logic [7:0]                    wake_irq_flags_i,
	input  wire logic [7:0]                    wake_periph_flags_i,
	output logic                               pc_load_o,
	output logic      [sfr_init_pkg::PC_W-1:0] pc_vector_o,
	// Port A
	input  wire logic [7:0]                    port_a_pins_i,
	output logic      [7:0]                    port_a_latch_o,
	output logic      [7:0]                    port_a_direction_o,
	output logic                               long_write_enable_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]                  regs_q [sfr_init_pkg::NUM_REGS];  // Register array
	logic [7:0]                  regs_d [sfr_init_pkg::NUM_REGS];  // Next register values
	logic [7:0]                  pins_meta_q;                       // First sync stage
	logic [7:0]                  pins_sync_q;                       // Second sync stage
	logic                        wait_q;                            // Waitrequest flop
	logic [31:0]                 rdata_q;                           // Read data flop
	logic                        pc_load_q;                         // Vector load pulse
	logic [sfr_init_pkg::PC_W-1:0] pc_vec_q;                        // Vector value
	sfr_init_pkg::event_t        ev;                                // Event this cycle
	logic                        bus_req;                           // Read or write pending
	logic                        addr_ok;                           // Address is mapped
	logic                        wr_fire;                           // Write commits now
	logic                        vector_take;                       // Interrupt wake vectors

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// True when the oscillator mode frees port A bit 6
	function automatic logic osc_io_mode(input logic [7:0] osc);
		return (osc[2:0] == sfr_init_pkg::OSC_EXT_CLOCK_IO) ||
		       (osc[2:0] == sfr_init_pkg::OSC_RC_IO);
	endfunction

	// Bits of a register that exist right now
	function automatic logic [7:0] live_mask(input int idx, input logic [7:0] osc);
		logic [7:0] m;
		m = sfr_init_pkg::REG_IMPL[idx];
		if ((idx >= sfr_init_pkg::IDX_PA_LATCH) && (idx <= sfr_init_pkg::IDX_PA_PINS) &&
		    !osc_io_mode(osc))
			m = m & ~sfr_init_pkg::PA_BIT6;
		return m;
	endfunction

	// Bits that software may write
	function automatic logic [7:0] write_mask(input int idx);
		case (idx)
			sfr_init_pkg::IDX_RST_CAUSE: return sfr_init_pkg::RST_CAUSE_WR;
			sfr_init_pkg::IDX_SP_STATUS: return sfr_init_pkg::SP_STATUS_WR;
			sfr_init_pkg::IDX_LVD_CTRL:  return sfr_init_pkg::LVD_CTRL_WR;
			sfr_init_pkg::IDX_PA_PINS:   return 8'h00;
			default:                     return 8'hff;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Event priority
	// ----------------------------------------------------------------
	// Colder resets win over warmer ones, any reset over a wake-up
	always_comb
	begin
		if (power_on_i)             ev = sfr_init_pkg::EV_POWER_ON;
		else if (brown_out_i)       ev = sfr_init_pkg::EV_BROWN_OUT;
		else if (master_clear_i)    ev = sfr_init_pkg::EV_MASTER_CLR;
		else if (watchdog_reset_i)  ev = sfr_init_pkg::EV_WATCHDOG;
		else if (instr_reset_i)     ev = sfr_init_pkg::EV_INSTR;
		else if (stack_reset_i)     ev = sfr_init_pkg::EV_STACK;
		else if (wake_watchdog_i)   ev = sfr_init_pkg::EV_WAKE_WDOG;
		else if (wake_irq_i)        ev = sfr_init_pkg::EV_WAKE_IRQ;
		else                        ev = sfr_init_pkg::EV_NONE;
	end

	// Bus decode
	assign bus_req     = read_i || write_i;
	assign addr_ok     = (address_i < 6'(sfr_init_pkg::NUM_REGS));
	assign wr_fire     = write_i && !wait_q && byteenable_i[0] && addr_ok;
	assign vector_take = (ev == sfr_init_pkg::EV_WAKE_IRQ) &&
	                     (global_high_irq_enable_i || global_low_irq_enable_i);

	// ----------------------------------------------------------------
	// Next register values
	// ----------------------------------------------------------------
	// Bus write first, then the event, then hardware side effects
	always_comb
	begin
		for (int i = 0; i < sfr_init_pkg::NUM_REGS; i++)
		begin
			regs_d[i] = regs_q[i];
			// Software write through the writable bits
			if (wr_fire && (address_i == 6'(i)))
				regs_d[i] = (regs_q[i] & ~write_mask(i)) | (writedata_i[7:0] & write_mask(i));
			// Defined entries load; the rest are left alone
			case (ev)
				sfr_init_pkg::EV_POWER_ON,
				sfr_init_pkg::EV_BROWN_OUT:
					if (sfr_init_pkg::COLD_DEF[i]) regs_d[i] = sfr_init_pkg::REG_INIT[i];
				sfr_init_pkg::EV_MASTER_CLR,
				sfr_init_pkg::EV_WATCHDOG,
				sfr_init_pkg::EV_INSTR,
				sfr_init_pkg::EV_STACK:
					if (sfr_init_pkg::WARM_DEF[i]) regs_d[i] = sfr_init_pkg::REG_INIT[i];
				sfr_init_pkg::EV_WAKE_WDOG,
				sfr_init_pkg::EV_WAKE_IRQ:
					if (sfr_init_pkg::WAKE_DEF[i]) regs_d[i] = sfr_init_pkg::REG_INIT[i];
				default: ;  // Unknown and unchanged entries hold
			endcase
		end

		// Reset cause: fixed part plus the condition bits
		case (ev)
			sfr_init_pkg::EV_POWER_ON,
			sfr_init_pkg::EV_BROWN_OUT:
				regs_d[sfr_init_pkg::IDX_RST_CAUSE] = sfr_init_pkg::RST_CAUSE_COLD |
					{6'h00, reset_cause_q_i[0], 1'b0};
			sfr_init_pkg::EV_MASTER_CLR,
			sfr_init_pkg::EV_WATCHDOG,
			sfr_init_pkg::EV_INSTR,
			sfr_init_pkg::EV_STACK:
				regs_d[sfr_init_pkg::IDX_RST_CAUSE] = {4'h1, reset_cause_q_i[2:1],
					regs_q[sfr_init_pkg::IDX_RST_CAUSE][1:0]};
			sfr_init_pkg::EV_WAKE_WDOG,
			sfr_init_pkg::EV_WAKE_IRQ:
				regs_d[sfr_init_pkg::IDX_RST_CAUSE][3:2] = reset_cause_q_i[2:1];
			default: ;
		endcase

		// Long write enable clears on power-on and master clear only
		if ((ev == sfr_init_pkg::EV_POWER_ON) || (ev == sfr_init_pkg::EV_MASTER_CLR))
			regs_d[sfr_init_pkg::IDX_LONG_WRITE] = 8'h00;

		// Interrupt wake with a global enable pushes the program counter
		if (vector_take)
		begin
			regs_d[sfr_init_pkg::IDX_STK_UPPER] = {3'h0, pc_i[20:16]};
			regs_d[sfr_init_pkg::IDX_STK_HIGH]  = pc_i[15:8];
			regs_d[sfr_init_pkg::IDX_STK_LOW]   = pc_i[7:0];
			regs_d[sfr_init_pkg::IDX_STK_PTR]   = {regs_q[sfr_init_pkg::IDX_STK_PTR][7:5],
				regs_q[sfr_init_pkg::IDX_STK_PTR][4:0] + 5'h01};
		end

		// Wake source flags; setting wins over a software clear
		if (ev == sfr_init_pkg::EV_WAKE_IRQ)
		begin
			regs_d[sfr_init_pkg::IDX_IRQ_CTRL] = regs_d[sfr_init_pkg::IDX_IRQ_CTRL] |
				wake_irq_flags_i;
			regs_d[sfr_init_pkg::IDX_PERIPH_REQ] = regs_d[sfr_init_pkg::IDX_PERIPH_REQ] |
				wake_periph_flags_i;
			if ((wake_irq_flags_i | wake_periph_flags_i) == 8'h00)
				regs_d[sfr_init_pkg::IDX_IRQ_CTRL] = regs_d[sfr_init_pkg::IDX_IRQ_CTRL] |
					sfr_init_pkg::IRQ_FALLBACK;
		end

		// Pin register follows the synchronised pins
		regs_d[sfr_init_pkg::IDX_PA_PINS] = pins_sync_q;

		// Strip bits that do not exist in the present mode
		for (int i = 0; i < sfr_init_pkg::NUM_REGS; i++)
			regs_d[i] = regs_d[i] & live_mask(i, regs_q[sfr_init_pkg::IDX_OSC_MODE]);
	end

	// ----------------------------------------------------------------
	// Register array
	// ----------------------------------------------------------------
	// Asynchronous reset loads REG_INIT, masked to the live bits, into every register, so the reset cause reads 8'h1e (bit 0 clear) and long write enable is set
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			for (int i = 0; i < sfr_init_pkg::NUM_REGS; i++)
				regs_q[i] <= sfr_init_pkg::REG_INIT[i] &
					live_mask(i, sfr_init_pkg::REG_INIT[sfr_init_pkg::IDX_OSC_MODE]);
		else if (clk_en_i)
			for (int i = 0; i < sfr_init_pkg::NUM_REGS; i++)
				regs_q[i] <= regs_d[i];
	end

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	// Two stages before any logic reads the pins
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pins_meta_q <= 8'h00;
			pins_sync_q <= 8'h00;
		end
		else if (clk_en_i)
		begin
			pins_meta_q <= port_a_pins_i;
			pins_sync_q <= pins_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Avalon-MM handshake
	// ----------------------------------------------------------------
	// One wait cycle: data captured, then waitrequest drops for a cycle
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end
		else if (clk_en_i)
		begin
			if (bus_req && wait_q)
			begin
				wait_q <= 1'b0;
				// Unmapped words read zero
				rdata_q <= addr_ok ? {24'h00_0000, regs_q[address_i]} : 32'h0000_0000;
			end
			else
				wait_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt vector load
	// ----------------------------------------------------------------
	// High-priority wake goes to the high vector, else the low one
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pc_load_q <= 1'b0;
			pc_vec_q  <= 21'h000000;
		end
		else if (clk_en_i)
		begin
			pc_load_q <= vector_take;
			if (vector_take)
				pc_vec_q <= wake_irq_high_i ? sfr_init_pkg::VEC_HIGH : sfr_init_pkg::VEC_LOW;
		end
	end

	// Outputs straight from flops
	assign readdata_o          = rdata_q;
	assign waitrequest_o       = wait_q;
	assign pc_load_o           = pc_load_q;
	assign pc_vector_o         = pc_vec_q;
	assign port_a_latch_o      = regs_q[sfr_init_pkg::IDX_PA_LATCH];
	assign port_a_direction_o  = regs_q[sfr_init_pkg::IDX_PA_DIR];
	assign long_write_enable_o = regs_q[sfr_init_pkg::IDX_LONG_WRITE][0];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	logic warm_ev;  // Any reset other than the cold ones
	assign warm_ev = (ev == sfr_init_pkg::EV_MASTER_CLR) || (ev == sfr_init_pkg::EV_WATCHDOG) ||
	                 (ev == sfr_init_pkg::EV_INSTR) || (ev == sfr_init_pkg::EV_STACK);

	property p_vector;
		clk_en_i && vector_take && wake_irq_high_i |=> pc_load_o && (pc_vector_o == 21'h000008);
	endproperty
	a_vector: assert property (p_vector) else $error("vector not loaded");
	property p_push;
		clk_en_i && vector_take |=>
			(regs_q[sfr_init_pkg::IDX_STK_LOW] == $past(pc_i[7:0])) &&
			(regs_q[sfr_init_pkg::IDX_STK_PTR][4:0] ==
			 $past(regs_q[sfr_init_pkg::IDX_STK_PTR][4:0]) + 5'h01);
	endproperty
	a_push: assert property (p_push) else $error("stack push wrong");
	property p_wake_flag;
		clk_en_i && (ev == sfr_init_pkg::EV_WAKE_IRQ) |=>
			(regs_q[sfr_init_pkg::IDX_IRQ_CTRL] | regs_q[sfr_init_pkg::IDX_PERIPH_REQ]) != 8'h00;
	endproperty
	a_wake_flag: assert property (p_wake_flag) else $error("no wake flag");
	property p_bit6;
		!osc_io_mode(regs_q[sfr_init_pkg::IDX_OSC_MODE]) ##1
		!osc_io_mode(regs_q[sfr_init_pkg::IDX_OSC_MODE]) && $past(clk_en_i) |->
			!port_a_latch_o[sfr_init_pkg::PA_GATED_BIT] &&
			!port_a_direction_o[sfr_init_pkg::PA_GATED_BIT];
	endproperty
	a_bit6: assert property (p_bit6) else $error("port bit 6 live");
	property p_lwe_kept;
		clk_en_i && !wr_fire && (warm_ev || (ev == sfr_init_pkg::EV_BROWN_OUT)) &&
		(ev != sfr_init_pkg::EV_MASTER_CLR) |=> $stable(long_write_enable_o);
	endproperty
	a_lwe_kept: assert property (p_lwe_kept) else $error("long write enable lost");
	property p_unimpl;
		(regs_q[sfr_init_pkg::IDX_RST_CAUSE][5] == 1'b0) &&
		(regs_q[sfr_init_pkg::IDX_T1_CTRL][6] == 1'b0) &&
		(regs_q[sfr_init_pkg::IDX_T2_CTRL][7] == 1'b0);
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");
	property p_unknown_kept;
		clk_en_i && warm_ev && !wr_fire |=> $stable(regs_q[sfr_init_pkg::IDX_T1_HIGH]);
	endproperty
	a_unknown_kept: assert property (p_unknown_kept) else $error("timer1 count changed");
	property p_cause_cold;
		clk_en_i && (ev == sfr_init_pkg::EV_BROWN_OUT) |=>
			regs_q[sfr_init_pkg::IDX_RST_CAUSE] == (8'h1c | {6'h00, $past(reset_cause_q_i[0]), 1'b0});
	endproperty
	a_cause_cold: assert property (p_cause_cold) else $error("reset cause wrong");
	property p_t1_warm;
		clk_en_i && warm_ev && !wr_fire |=> $stable(regs_q[sfr_init_pkg::IDX_T1_CTRL]);
	endproperty
	a_t1_warm: assert property (p_t1_warm) else $error("timer1 control changed");
	property p_t2;
		clk_en_i && warm_ev |=> regs_q[sfr_init_pkg::IDX_T2_CTRL] == 8'h00;
	endproperty
	a_t2: assert property (p_t2) else $error("timer2 control not cleared");
	property p_t2_wake;
		clk_en_i && ((ev == sfr_init_pkg::EV_WAKE_WDOG) || (ev == sfr_init_pkg::EV_WAKE_IRQ)) &&
		!wr_fire |=> $stable(regs_q[sfr_init_pkg::IDX_T2_CTRL]);
	endproperty
	a_t2_wake: assert property (p_t2_wake) else $error("timer2 control lost on wake");
	property p_period;
		clk_en_i && (ev != sfr_init_pkg::EV_NONE) |=> regs_q[sfr_init_pkg::IDX_T2_PERIOD] == 8'hff;
	endproperty
	a_period: assert property (p_period) else $error("period not all ones");
	property p_bus_answer;
		bus_req && wait_q && clk_en_i |=> !waitrequest_o;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("no bus answer");
	c_irq_wake:  cover property (clk_en_i && vector_take);
	c_cold:      cover property (clk_en_i && ev == sfr_init_pkg::EV_POWER_ON);
	c_bus_write: cover property (wr_fire && clk_en_i);

endmodule // sfr_reset_initializer

//--- verilog/sfr_init_pkg.sv
// Constants and types for the special function register initialiser
package sfr_init_pkg;

	// ----------------------------------------------------------------
	// Register file geometry
	// ----------------------------------------------------------------
	localparam int NUM_REGS  = 35;           // Registers held by the block
	localparam int ADDR_W    = 6;            // Avalon word address width
	localparam int PC_W      = 21;           // Program counter width

	// Word index of each register (byte address is four times the index)
	localparam int IDX_PTR1_HIGH   = 0;
	localparam int IDX_PTR1_LOW    = 1;
	localparam int IDX_BANK_SEL    = 2;
	localparam int IDX_PTR2_HIGH   = 3;
	localparam int IDX_PTR2_LOW    = 4;
	localparam int IDX_ALU_FLAGS   = 5;
	localparam int IDX_T0_HIGH     = 6;
	localparam int IDX_T0_LOW      = 7;
	localparam int IDX_T0_CTRL     = 8;
	localparam int IDX_OSC_CTRL    = 9;
	localparam int IDX_LVD_CTRL    = 10;
	localparam int IDX_WDOG_CTRL   = 11;
	localparam int IDX_RST_CAUSE   = 12;
	localparam int IDX_T1_HIGH     = 13;
	localparam int IDX_T1_LOW      = 14;
	localparam int IDX_T1_CTRL     = 15;
	localparam int IDX_T2_COUNT    = 16;
	localparam int IDX_T2_PERIOD   = 17;
	localparam int IDX_T2_CTRL     = 18;
	localparam int IDX_SP_BUFFER   = 19;
	localparam int IDX_SP_ADDRESS  = 20;
	localparam int IDX_SP_STATUS   = 21;
	localparam int IDX_SP_CTRL_A   = 22;
	localparam int IDX_SP_CTRL_B   = 23;
	localparam int IDX_STK_UPPER   = 24;
	localparam int IDX_STK_HIGH    = 25;
	localparam int IDX_STK_LOW     = 26;
	localparam int IDX_STK_PTR     = 27;
	localparam int IDX_PA_LATCH    = 28;
	localparam int IDX_PA_DIR      = 29;
	localparam int IDX_PA_PINS     = 30;
	localparam int IDX_OSC_MODE    = 31;
	localparam int IDX_LONG_WRITE  = 32;
	localparam int IDX_IRQ_CTRL    = 33;
	localparam int IDX_PERIPH_REQ  = 34;

	// ----------------------------------------------------------------
	// Initial values, defined-value maps and bit masks
	// ----------------------------------------------------------------
	// Value loaded on a reset where the register has a defined entry
	localparam logic [7:0] REG_INIT [NUM_REGS] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'hff, 8'h00, 8'h05, 8'h00, 8'h1e, 8'h00, 8'h00, 8'h00,
		8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00,
		8'h01, 8'h00, 8'h00};
	// Implemented bits; all others read zero
	localparam logic [7:0] REG_IMPL [NUM_REGS] = '{
		8'h0f, 8'hff, 8'h0f, 8'h0f, 8'hff, 8'h1f, 8'hff, 8'hff,
		8'hff, 8'h01, 8'h3f, 8'h01, 8'hdf, 8'hff, 8'hff, 8'hbf,
		8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'h1f, 8'hff, 8'hff, 8'hdf, 8'hff, 8'hff, 8'hff, 8'h07,
		8'h01, 8'hff, 8'hff};
	localparam logic [NUM_REGS-1:0] COLD_DEF = 35'h6aff68f0d; // Set on power-on, brown-out
	localparam logic [NUM_REGS-1:0] WARM_DEF = 35'h62ff60f0d; // Set on the other resets
	localparam logic [NUM_REGS-1:0] WAKE_DEF = 35'h000020000; // Set on wake-up
	localparam logic [7:0] RST_CAUSE_WR   = 8'hc3;           // Software-writable bits
	localparam logic [7:0] SP_STATUS_WR   = 8'hc0;
	localparam logic [7:0] LVD_CTRL_WR    = 8'h1f;
	localparam logic [7:0] RST_CAUSE_COLD = 8'h1c;           // Fixed part, cold reset
	localparam logic [7:0] PA_BIT6        = 8'h40;           // Oscillator-gated bit
	localparam logic [7:0] IRQ_FALLBACK   = 8'h01;           // Wake flag if none given
	localparam int         PA_GATED_BIT   = 6;

	// ----------------------------------------------------------------
	// Vectors and oscillator modes
	// ----------------------------------------------------------------
	localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
	localparam logic [PC_W-1:0] VEC_LOW  = 21'h000018;
	localparam logic [2:0] OSC_EXT_CLOCK_IO = 3'h5;      // Mode codes are arbitrary
	localparam logic [2:0] OSC_RC_IO        = 3'h7;

	// Highest-priority reset or wake event seen in a cycle
	typedef enum logic [3:0] {
		EV_NONE       = 4'h0,
		EV_POWER_ON   = 4'h1,
		EV_BROWN_OUT  = 4'h2,
		EV_MASTER_CLR = 4'h3,
		EV_WATCHDOG   = 4'h4,
		EV_INSTR      = 4'h5,
		EV_STACK      = 4'h6,
		EV_WAKE_WDOG  = 4'h7,
		EV_WAKE_IRQ   = 4'h8
	} event_t;

endpackage

//--- verification/core_event_model.sv
// Behavioural processor core and reset source driving the initialiser
module core_event_model (
	input  wire logic        clk_i,
	output logic      [7:0]  event_o,
	output logic      [20:0] pc_o,
	output logic             irq_high_o,
	output logic      [1:0]  gen_o,
	output logic      [7:0]  flags_o,
	output logic      [7:0]  pflags_o,
	output logic      [2:0]  cause_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// Idle state: no event, enables off
	// ----------------------------------------------------------------
	initial
	begin
		event_o = 8'h00;
		pc_o = 21'h000000;
		irq_high_o = 1'b0;
		gen_o = 2'h0;
		flags_o = 8'h00;
		pflags_o = 8'h00;
		cause_o = 3'h0;
	end
	// One-cycle pulse on event k; a quiet edge follows so calls chain
	task automatic fire(input int k, input logic [2:0] q);
		cause_o <= q;
		event_o <= 8'h01 << k;
		@(posedge clk_i);
		event_o <= 8'h00;
		@(posedge clk_i);
	endtask
	// Interrupt wake; enables [1] high, [0] low
	task automatic wake(input logic [20:0] pc, input logic hi, input logic [1:0] g,
		input logic [7:0] f, input logic [7:0] pf);
		pc_o <= pc;
		irq_high_o <= hi;
		gen_o <= g;
		flags_o <= f;
		pflags_o <= pf;
		fire(7, 3'h0);
	endtask
endmodule // core_event_model

//--- verification/tb_sfr_reset_initializer.sv
// Self-checking bench for the register initialiser
module tb_sfr_reset_initializer;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i, reset_n_i, read_i, write_i, waitrequest_o, pc_load_o, lwe;
	logic [5:0]  address_i;
	logic [31:0] writedata_i, readdata_o, q;
	logic [3:0]  byteenable_i;
	logic [7:0]  ev, fl, pfl, pins, lat, dir;
	logic [20:0] pc, vec;
	logic [1:0]  gen;
	logic [2:0]  cq;
	logic        hi;
	int          fail_count, checks_done;
	core_event_model core (.clk_i(clk_i), .event_o(ev), .pc_o(pc), .irq_high_o(hi),
		.gen_o(gen), .flags_o(fl), .pflags_o(pfl), .cause_o(cq));
	sfr_reset_initializer dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
		.address_i(address_i), .read_i(read_i), .write_i(write_i),
		.writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .power_on_i(ev[0]), .brown_out_i(ev[1]),
		.master_clear_i(ev[2]), .watchdog_reset_i(ev[3]), .instr_reset_i(ev[4]),
		.stack_reset_i(ev[5]), .wake_watchdog_i(ev[6]), .wake_irq_i(ev[7]),
		.reset_cause_q_i(cq), .pc_i(pc), .wake_irq_high_i(hi),
		.global_high_irq_enable_i(gen[1]), .global_low_irq_enable_i(gen[0]),
		.wake_irq_flags_i(fl), .wake_periph_flags_i(pfl), .pc_load_o(pc_load_o),
		.pc_vector_o(vec), .port_a_pins_i(pins), .port_a_latch_o(lat),
		.port_a_direction_o(dir), .long_write_enable_o(lwe));
	// ----------------------------------------------------------------
	// Clock, verdict, compare and bus tasks
	// ----------------------------------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Counts, then the verdict
	task automatic stop_test;
		$display("checks %0d errors %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Avalon transfer: held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		address_i <= a;
		read_i <= !w;
		write_i <= w;
		writedata_i <= {24'h000000, d};
		byteenable_i <= be;
		do
		begin
			@(posedge clk_i);
			n++;
		end while (waitrequest_o !== 1'b0 && n < 40);
		q = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
		@(posedge clk_i);
		if (n >= 40)
		begin
			fail_count++;
			stop_test();
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, 4'h1);
		chk(q, {24'h000000, e});
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{reset_n_i, read_i, write_i, address_i, writedata_i, byteenable_i} = '0;
		pins = 8'hff;
		repeat (6) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		rd(12, 8'h1e);
		rd(17, 8'hff);
		rd(40, 8'h00);
		bus(1'b1, 20, 8'h99, 4'h0);
		rd(20, 8'h00);
		wr(15, 8'hff);
		wr(1, 8'h77);
		wr(32, 8'h01);
		wr(20, 8'h5a);
		wr(18, 8'hff);
		wr(17, 8'h12);
		core.fire(6, 3'h0);
		rd(17, 8'hff);
		rd(20, 8'h5a);
		rd(18, 8'h7f);
		core.fire(3, 3'h2);
		rd(18, 8'h00);
		rd(20, 8'h00);
		rd(15, 8'hbf);
		rd(32, 8'h01);
		chk(lwe, 1'b1);
		rd(1, 8'h77);
		rd(12, 8'h16);
		core.fire(2, 3'h0);
		rd(32, 8'h00);
		rd(15, 8'hbf);
		wr(32, 8'h01);
		core.fire(1, 3'h1);
		rd(15, 8'h00);
		rd(12, 8'h1e);
		rd(32, 8'h01);
		// Every reset kind clears the serial and timer 2 controls
		for (int k = 0; k < 6; k++)
		begin
			wr(23, 8'hc3);
			wr(18, 8'h11);
			core.fire(k, 3'h0);
			rd(23, 8'h00);
			rd(18, 8'h00);
		end
		core.wake(21'h012345, 1'b0, 2'h1, 8'h00, 8'h00);
		chk(pc_load_o, 1'b1);
		chk(vec, 21'h000018);
		rd(24, 8'h01);
		rd(25, 8'h23);
		rd(26, 8'h45);
		rd(27, 8'h01);
		rd(33, 8'h01);
		core.wake(21'h1abcde, 1'b1, 2'h2, 8'h00, 8'h04);
		chk(vec, 21'h000008);
		rd(24, 8'h1a);
		rd(27, 8'h02);
		rd(34, 8'h04);
		core.wake(21'h000777, 1'b1, 2'h0, 8'h10, 8'h02);
		chk(pc_load_o, 1'b0);
		rd(27, 8'h02);
		rd(34, 8'h06);
		rd(33, 8'h11);
		wr(31, 8'h05);
		wr(28, 8'hff);
		rd(28, 8'hff);
		wr(31, 8'h00);
		rd(28, 8'hbf);
		chk(lat, 8'hbf);
		chk(dir, 8'hbf);
		rd(30, 8'hbf);
		wr(31, 8'h07);
		wr(28, 8'hff);
		rd(28, 8'hff);
		stop_test();
	end
endmodule // tb_sfr_reset_initializer
